// file: verilog/fault_pkg.sv
package fault_pkg;

  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_MS        = 100;
  localparam int TICK_DEFAULT   = TICK_MS * 1000000 / CLK_PERIOD_NS;

  localparam int VALVE_NORM_MS  = 60000;
  localparam int VALVE_DIAG_MS  = 4000;
  localparam int DRAIN_MAX_MS   = 300000;
  localparam int PUMP_OFF_MS    = 300000;
  localparam int TRIAC_MS       = 3000;
  localparam int TRIAC_PAUSE_MS = 10000;
  localparam int TSENSE_MS      = 1000;
  localparam int SAT_LINK_MS    = 25000;
  localparam int SAT_PAUSE_MS   = 10000;

  // tick counts: least times round up (sensing time takes one tick more than 1000/100), longest times round down
  localparam logic [11:0] VALVE_NORM_T  = 12'((VALVE_NORM_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] VALVE_DIAG_T  = 12'((VALVE_DIAG_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] DRAIN_MAX_T   = 12'(DRAIN_MAX_MS / TICK_MS);
  localparam logic [11:0] PUMP_OFF_T    = 12'((PUMP_OFF_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] TRIAC_T       = 12'((TRIAC_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] TRIAC_PAUSE_T = 12'((TRIAC_PAUSE_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] TSENSE_T      = 12'(TSENSE_MS / TICK_MS + 1);
  localparam logic [11:0] SAT_LINK_T    = 12'((SAT_LINK_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] SAT_PAUSE_T   = 12'((SAT_PAUSE_MS + TICK_MS - 1) / TICK_MS);

  localparam logic [2:0]  SAT_TRIALS     = 3'h5;
  localparam logic [7:0]  TSENSE_POS_LIM = 8'hfa;
  localparam logic [7:0]  TSENSE_NEG_LIM = 8'h05;
  localparam logic [11:0] LOAD_MIN_G     = 12'h258;
  localparam logic [11:0] LOAD_MAX_G     = 12'h7d0;

  localparam logic [11:0] STATUS_OFF = 12'h000;
  localparam logic [11:0] MASK_OFF   = 12'h004;
  localparam logic [11:0] ALARM_OFF  = 12'h008;
  localparam logic [11:0] CTRL_OFF   = 12'h00c;

  localparam int NUM_ALARMS = 10;
  localparam int A_VALVE    = 0;
  localparam int A_WLINK    = 1;
  localparam int A_WFAULT   = 2;
  localparam int A_CURRENT  = 3;
  localparam int A_LTRIAC   = 4;
  localparam int A_TSENSE   = 5;
  localparam int A_SATLINK  = 6;
  localparam int A_SATBOARD = 7;
  localparam int A_SOFTENER = 8;
  localparam int A_BRINE    = 9;

  localparam logic [NUM_ALARMS-1:0] MASK_RESET = 10'h000;
  localparam logic                  CTRL_RESET = 1'b1;

  typedef struct packed {
    logic        power_off;
    logic        power_fail;
    logic        start_pause;
    logic        diag_mode;
    logic        setup_mode;
    logic        flow_running;
    logic        valve_driven;
    logic        lvl_overload;
    logic        lvl_first;
    logic        lvl_antiboil;
    logic        weight_link_err;
    logic        weight_sensor_bad;
    logic        heater_test_step;
    logic [11:0] water_load_g;
    logic        zero_cross_offset_fail;
    logic        zero_cross_missing;
    logic        aux_load_triac_drive;
    logic        aux_load_triac_sense_hi;
    logic        half_wave_pos;
    logic [7:0]  triac_sense_adc;
    logic        sat_link_ok;
    logic        sat_board_fault;
    logic        regen_active;
    logic        level_float;
    logic        density_float;
    logic        brine_drive;
    logic        brine_current;
    logic        brine_active;
  } sensors_t;

  typedef struct packed {
    logic door_lock;
    logic door_release;
    logic drain_pump;
    logic spin_limit;
    logic machine_stop;
    logic weight_zero;
    logic sat_board_power;
  } actions_t;

  typedef enum logic [1:0] {D_IDLE, D_RUN, D_OFF, D_EMPTY} drain_state_t;
  typedef enum logic       {T_WATCH, T_PAUSE} triac_state_t;
  typedef enum logic       {S_ON, S_PAUSE} sat_state_t;

endpackage

// file: verilog/appliance_fault_monitor.sv
// Notes on behaviour
// - flow without valves: alarm after 60s/4s
// - valve alarm: door locked, drain 5 minutes max
// - level stuck: pump off 5 min, restart
// - softener, pump, valve, triac alarms: power-off only
// - weight link error: zero weight, cleared by press
// - diagnostic heater test: load outside 600-2000 g
// - weight sensor bad: fault alarm, zero weight
// - current sensor fault: limit spin speed
// - triac mismatch: open load or shorted triac
// - triac alarm: two 3s trials, 10s pause
// - set-up mode: alarm after first trial
// - load triac alarm: safety drain, door opens
// - triac sensing beyond 250/5 over 1s
// - sensing alarm: drain first, power fail restarts
// - satellite link alarm after 25s of retries
// - satellite board fault: five trials, 10s off
// - float unchanged whole regeneration: alarm, stop
// - brine pump drive/current mismatch: alarm, stop
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module appliance_fault_monitor
  import fault_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DEFAULT
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire sensors_t              sens_pin,
  output var  actions_t              act,
  output var  logic [NUM_ALARMS-1:0] alarm,
  output var  logic                  irq
);

  // input synchroniser and tick divider
  sensors_t    sync1_reg, s;
  logic [23:0] tick_cnt_reg, tick_cnt_next;
  logic        tick_reg, tick_next;

  always_comb begin
    tick_next = (tick_cnt_reg == 24'(TICK_CYCLES - 1));
    tick_cnt_next = tick_next ? 24'h000000 : tick_cnt_reg + 24'h000001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg    <= '0;
      s            <= '0;
      tick_cnt_reg <= 24'h000000;
      tick_reg     <= 1'b0;
    end else begin
      sync1_reg    <= sens_pin;
      s            <= sync1_reg;
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // persistence timers: valve, triac sensing, satellite link
  logic [NUM_ALARMS-1:0] alarm_reg, alarm_next;
  logic [2:0]  p_cond;
  logic [2:0]  p_hit;
  logic [11:0] p_lim [3];
  logic [11:0] p_cnt_reg [3];
  logic [11:0] p_cnt_next [3];
  logic        tsense_out;

  always_comb begin
    tsense_out = s.half_wave_pos ? (s.triac_sense_adc > TSENSE_POS_LIM)
                                 : (s.triac_sense_adc > TSENSE_NEG_LIM);
    p_cond[0] = s.flow_running & !s.valve_driven;
    p_cond[1] = tsense_out;
    p_cond[2] = !s.sat_link_ok;
    p_lim[0]  = s.diag_mode ? VALVE_DIAG_T : VALVE_NORM_T;
    p_lim[1]  = TSENSE_T;
    p_lim[2]  = SAT_LINK_T;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_persist
      always_comb begin
        if (!p_cond[gi] || s.power_off)
          p_cnt_next[gi] = 12'h000;
        else if (tick_reg && p_cnt_reg[gi] < p_lim[gi])
          p_cnt_next[gi] = p_cnt_reg[gi] + 12'h001;
        else
          p_cnt_next[gi] = p_cnt_reg[gi];
        p_hit[gi] = p_cond[gi] && p_cnt_reg[gi] >= p_lim[gi];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          p_cnt_reg[gi] <= 12'h000;
        else
          p_cnt_reg[gi] <= p_cnt_next[gi];
      end
    end
  endgenerate

  // load triac trials
  triac_state_t t_reg, t_next;
  logic [11:0]  tc_reg, tc_next;
  logic         second_reg, second_next;
  logic         mismatch, ltriac_set;

  always_comb begin
    mismatch = (s.aux_load_triac_drive & s.aux_load_triac_sense_hi) |
               (!s.aux_load_triac_drive & !s.aux_load_triac_sense_hi);
    t_next = t_reg;
    tc_next = tc_reg;
    second_next = second_reg;
    ltriac_set = 1'b0;
    unique case (t_reg)
      T_WATCH: begin
        if (!mismatch || alarm_reg[A_LTRIAC]) begin
          tc_next = 12'h000;
          second_next = 1'b0;
        end else if (tc_reg >= TRIAC_T) begin
          tc_next = 12'h000;
          if (second_reg || s.setup_mode) begin
            ltriac_set = 1'b1;
            second_next = 1'b0;
          end else begin
            t_next = T_PAUSE;
          end
        end else if (tick_reg) begin
          tc_next = tc_reg + 12'h001;
        end
      end
      T_PAUSE: begin
        if (tc_reg >= TRIAC_PAUSE_T) begin
          t_next = T_WATCH;
          tc_next = 12'h000;
          second_next = 1'b1;
        end else if (tick_reg) begin
          tc_next = tc_reg + 12'h001;
        end
      end
    endcase
    if (s.power_off) begin
      t_next = T_WATCH;
      tc_next = 12'h000;
      second_next = 1'b0;
    end
  end

  // satellite board fault trials
  sat_state_t sat_reg, sat_next;
  logic [11:0] st_reg, st_next;
  logic [2:0]  trial_reg, trial_next;
  logic        satboard_set;

  always_comb begin
    sat_next = sat_reg;
    st_next = st_reg;
    trial_next = trial_reg;
    satboard_set = 1'b0;
    unique case (sat_reg)
      S_ON: begin
        if (!s.sat_board_fault || alarm_reg[A_SATBOARD]) begin
          trial_next = 3'h0;
        end else if (tick_reg) begin
          trial_next = trial_reg + 3'h1;
          if (trial_next == SAT_TRIALS) begin
            satboard_set = 1'b1;
          end else begin
            sat_next = S_PAUSE;
            st_next = 12'h000;
          end
        end
      end
      S_PAUSE: begin
        if (st_reg >= SAT_PAUSE_T)
          sat_next = S_ON;
        else if (tick_reg)
          st_next = st_reg + 12'h001;
      end
    endcase
    if (s.power_off) begin
      sat_next = S_ON;
      st_next = 12'h000;
      trial_next = 3'h0;
    end
  end

  // softener float watch over regeneration
  logic regen_prev_reg, lvl_prev_reg, den_prev_reg;
  logic lvl_chg_reg, den_chg_reg, lvl_chg_next, den_chg_next;
  logic soft_set;

  always_comb begin
    lvl_chg_next = lvl_chg_reg | (s.level_float != lvl_prev_reg);
    den_chg_next = den_chg_reg | (s.density_float != den_prev_reg);
    if (s.regen_active && !regen_prev_reg) begin
      lvl_chg_next = 1'b0;
      den_chg_next = 1'b0;
    end
    soft_set = !s.regen_active && regen_prev_reg &&
               !(lvl_chg_reg && den_chg_reg);
  end

  // safety drain sequencer
  drain_state_t d_reg, d_next;
  logic [11:0]  dt_reg, dt_next;
  logic         all_open, drain_req, triac_drain;

  always_comb begin
    all_open = !(s.lvl_overload | s.lvl_first | s.lvl_antiboil);
    triac_drain = alarm_reg[A_LTRIAC] | alarm_reg[A_TSENSE];
    drain_req = alarm_reg[A_VALVE] | triac_drain;
    d_next = d_reg;
    dt_next = dt_reg;
    unique case (d_reg)
      D_IDLE: begin
        if (drain_req) begin
          d_next = D_RUN;
          dt_next = 12'h000;
        end
      end
      D_RUN: begin
        if (all_open) begin
          d_next = D_EMPTY;
        end else if (dt_reg >= DRAIN_MAX_T) begin
          d_next = D_OFF;
          dt_next = 12'h000;
        end else if (tick_reg) begin
          dt_next = dt_reg + 12'h001;
        end
      end
      D_OFF: begin
        if (dt_reg >= PUMP_OFF_T && s.lvl_overload) begin
          d_next = D_RUN;
          dt_next = 12'h000;
        end else if (tick_reg && dt_reg < PUMP_OFF_T) begin
          dt_next = dt_reg + 12'h001;
        end
      end
      D_EMPTY: begin
        if (!all_open) begin
          d_next = D_RUN;
          dt_next = 12'h000;
        end
      end
    endcase
    if (alarm_reg[A_TSENSE] && s.power_fail) begin
      d_next = D_RUN;
      dt_next = 12'h000;
    end
    if (s.power_off) begin
      d_next = D_IDLE;
      dt_next = 12'h000;
    end
  end

  // alarm latch, actions, register file
  logic [NUM_ALARMS-1:0] set_vec, status_reg, status_next;
  logic [NUM_ALARMS-1:0] mask_reg, mask_next;
  logic                  ctrl_en_reg, ctrl_en_next;
  actions_t              act_next;
  logic                  irq_next, pready_next, pslverr_next, wr_en;
  logic                  mapped;
  logic [31:0]           prdata_next;
  logic                  load_bad;

  always_comb begin
    load_bad = (s.water_load_g < LOAD_MIN_G) || (s.water_load_g > LOAD_MAX_G);
    set_vec = '0;
    set_vec[A_VALVE]    = p_hit[0];
    set_vec[A_WLINK]    = s.weight_link_err;
    set_vec[A_WFAULT]   = s.weight_sensor_bad |
                          (s.diag_mode & s.heater_test_step & load_bad);
    set_vec[A_CURRENT]  = s.zero_cross_offset_fail | s.zero_cross_missing;
    set_vec[A_LTRIAC]   = ltriac_set;
    set_vec[A_TSENSE]   = p_hit[1];
    set_vec[A_SATLINK]  = p_hit[2];
    set_vec[A_SATBOARD] = satboard_set;
    set_vec[A_SOFTENER] = soft_set;
    set_vec[A_BRINE]    = (s.brine_drive & !s.brine_current) |
                          (!s.brine_drive & s.brine_active);
    alarm_next = alarm_reg;
    if (s.start_pause) begin
      alarm_next[A_WLINK]  = 1'b0;
      alarm_next[A_WFAULT] = 1'b0;
    end
    if (s.power_off)
      alarm_next = '0;
    else if (ctrl_en_reg)
      alarm_next = alarm_next | set_vec;
    act_next.door_lock = alarm_reg[A_VALVE] |
                         (triac_drain & d_reg != D_EMPTY);
    act_next.door_release = triac_drain & d_reg == D_EMPTY &
                            !alarm_reg[A_VALVE];
    act_next.drain_pump = d_reg == D_RUN;
    act_next.spin_limit = alarm_reg[A_CURRENT];
    act_next.machine_stop = alarm_reg[A_SATBOARD] | alarm_reg[A_SOFTENER] |
                            alarm_reg[A_BRINE] |
                            (triac_drain & d_reg == D_EMPTY);
    act_next.weight_zero = alarm_reg[A_WLINK] | alarm_reg[A_WFAULT];
    act_next.sat_board_power = sat_reg == S_ON;
    mapped = paddr == STATUS_OFF || paddr == MASK_OFF ||
             paddr == ALARM_OFF || paddr == CTRL_OFF;
    wr_en = psel & penable & pready & pwrite & mapped;
    pready_next = psel & penable & !pready;
    pslverr_next = psel & penable & !pready & !mapped;
    prdata_next = 32'h00000000;
    if (psel && penable && !pready && !pwrite) begin
      unique case (paddr)
        STATUS_OFF: prdata_next = 32'(status_reg);
        MASK_OFF:   prdata_next = 32'(mask_reg);
        ALARM_OFF:  prdata_next = 32'(alarm_reg);
        CTRL_OFF:   prdata_next = 32'(ctrl_en_reg);
        default:    prdata_next = 32'h00000000;
      endcase
    end
    mask_next = mask_reg;
    ctrl_en_next = ctrl_en_reg;
    status_next = status_reg;
    if (wr_en && paddr == MASK_OFF)
      mask_next = pwdata[NUM_ALARMS-1:0];
    if (wr_en && paddr == CTRL_OFF)
      ctrl_en_next = pwdata[0];
    if (wr_en && paddr == STATUS_OFF)
      status_next = status_reg & ~pwdata[NUM_ALARMS-1:0];
    status_next = status_next | (alarm_next & ~alarm_reg);
    irq_next = |(status_next & mask_next);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_reg          <= T_WATCH;
      tc_reg         <= 12'h000;
      second_reg     <= 1'b0;
      sat_reg        <= S_ON;
      st_reg         <= 12'h000;
      trial_reg      <= 3'h0;
      regen_prev_reg <= 1'b0;
      lvl_prev_reg   <= 1'b0;
      den_prev_reg   <= 1'b0;
      lvl_chg_reg    <= 1'b0;
      den_chg_reg    <= 1'b0;
      d_reg          <= D_IDLE;
      dt_reg         <= 12'h000;
      alarm_reg      <= '0;
      status_reg     <= '0;
      mask_reg       <= MASK_RESET;
      ctrl_en_reg    <= CTRL_RESET;
      act            <= '0;
      alarm          <= '0;
      irq            <= 1'b0;
      prdata         <= 32'h00000000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
    end else begin
      t_reg          <= t_next;
      tc_reg         <= tc_next;
      second_reg     <= second_next;
      sat_reg        <= sat_next;
      st_reg         <= st_next;
      trial_reg      <= trial_next;
      regen_prev_reg <= s.regen_active;
      lvl_prev_reg   <= s.level_float;
      den_prev_reg   <= s.density_float;
      lvl_chg_reg    <= lvl_chg_next;
      den_chg_reg    <= den_chg_next;
      d_reg          <= d_next;
      dt_reg         <= dt_next;
      alarm_reg      <= alarm_next;
      status_reg     <= status_next;
      mask_reg       <= mask_next;
      ctrl_en_reg    <= ctrl_en_next;
      act            <= act_next;
      alarm          <= alarm_next;
      irq            <= irq_next;
      prdata         <= prdata_next;
      pready         <= pready_next;
      pslverr        <= pslverr_next;
    end
  end

endmodule

`default_nettype wire

// file: bench/fault_monitor_props.sv
`timescale 1ns/1ps
`default_nettype none
module fault_monitor_props
  import fault_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire sensors_t              sens_pin,
  input wire actions_t              act,
  input wire logic [NUM_ALARMS-1:0] alarm,
  input wire logic                  irq
);
  int flow_cnt;
  int quiet_cnt;

  // cycles of unbroken flow without valves, cycles since power came back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_cnt <= 0;
      quiet_cnt <= 0;
    end else begin
      flow_cnt <= (sens_pin.flow_running && !sens_pin.valve_driven) ?
                  flow_cnt + 1 : 0;
      quiet_cnt <= sens_pin.power_off ? 0 :
                   (quiet_cnt < 8 ? quiet_cnt + 1 : quiet_cnt);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  chk_valve_persist: assert property ($rose(alarm[A_VALVE]) |->
    $past(flow_cnt, 4) >= (VALVE_DIAG_T - 1) * TICK_CYCLES - 4)
    else $error("valve alarm without persistent flow");
  chk_valve_lock: assert property (alarm[A_VALVE] [*2] |-> act.door_lock)
    else $error("door not locked on valve alarm");
  chk_latch_hold: assert property (quiet_cnt >= 6 |=>
    (($past(alarm) & ~alarm) & 10'h3f9) == 10'h0)
    else $error("alarm cleared without power off");
  chk_weight_zero: assert property (|alarm[2:1] ##1 |alarm[2:1]
    |-> act.weight_zero)
    else $error("weight not forced to zero");
  chk_spin_limit: assert property (alarm[A_CURRENT] [*2] |-> act.spin_limit)
    else $error("spin not limited");
  chk_brine_fast: assert property ((sens_pin.brine_drive &&
    !sens_pin.brine_current && quiet_cnt >= 6) [*6] |-> alarm[A_BRINE])
    else $error("brine mismatch not flagged");
  chk_stop_act: assert property (|alarm[9:7] [*2] |-> act.machine_stop)
    else $error("machine not stopped");
  chk_release_after: assert property (act.door_release |->
    !act.drain_pump && |$past(alarm[5:4]))
    else $error("door released without triac alarm or while draining");

  cover property ($rose(alarm[A_VALVE]));
  cover property ($rose(alarm[A_LTRIAC]));
  cover property ($rose(act.door_release));
  cover property (pslverr);
endmodule

bind appliance_fault_monitor fault_monitor_props #(
  .TICK_CYCLES(TICK_CYCLES)
) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sens_pin(sens_pin), .act(act),
  .alarm(alarm), .irq(irq)
);
`default_nettype wire

// file: bench/appliance_model.sv
`timescale 1ns/1ps
`default_nettype none
module appliance_model
  import fault_pkg::*;
#(
  parameter int DRAIN_CYC = 40
) (
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire sensors_t cmd,
  input  wire logic     fill,
  input  wire logic     stuck,
  input  wire actions_t act,
  output var  sensors_t sens
);
  logic water_reg;
  int   pump_cnt;

  // tub empties after the pump has run long enough, unless a switch sticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      water_reg <= 1'h0;
      pump_cnt <= 0;
    end else if (fill) begin
      water_reg <= 1'h1;
      pump_cnt <= 0;
    end else if (act.drain_pump && !stuck) begin
      pump_cnt <= pump_cnt + 1;
      if (pump_cnt >= DRAIN_CYC)
        water_reg <= 1'h0;
    end
  end

  always_comb begin
    sens = cmd;
    sens.lvl_overload = water_reg;
    sens.lvl_first = water_reg;
    sens.lvl_antiboil = water_reg;
  end
endmodule
`default_nettype wire

// file: bench/appliance_fault_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module appliance_fault_monitor_tb
  import fault_pkg::*;
;
  localparam int TK = 4;
  localparam int DR = 15;
  localparam int DP = 14;
  localparam int MS = 12;
  localparam int SP = 10;
  localparam int NR = 11;
  localparam int IA[NR] = '{1, 2, 3, 3, 9, 9, 2, 2, 2, 2, 9};
  localparam int IB[NR] = '{11, 11, 13, 13, 12, 12, 11, 11, 11, 11, 12};
  localparam logic [NR-1:0] EX = 11'h0ff;
  localparam logic [11:0] LOADS[4] = '{12'h257, 12'h7d1, 12'h258, 12'h7d0};

  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  sensors_t              cmd;
  sensors_t              sens;
  sensors_t              base;
  sensors_t              s;
  actions_t              act;
  logic [NUM_ALARMS-1:0] alarm;
  logic                  irq;
  logic                  fill;
  logic                  stuck;
  logic [31:0]           rd;
  logic                  er;
  int                    n;
  int                    mismatches;
  int                    samples_checked;
  wire logic [16:0]      obs = {act, alarm};

  appliance_fault_monitor #(.TICK_CYCLES(TK)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sens_pin(sens), .act(act),
    .alarm(alarm), .irq(irq)
  );
  appliance_model i_model (
    .pclk(pclk), .presetn(presetn), .cmd(cmd), .fill(fill),
    .stuck(stuck), .act(act), .sens(sens)
  );

  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    check(32'h0, 32'h1);
    report_and_stop();
  endtask

  task automatic clk(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic drive(input sensors_t v);
    @(posedge pclk);
    cmd <= v;
  endtask

  task automatic fillup(input logic st);
    @(posedge pclk);
    fill <= 1'h1;
    stuck <= st;
    @(posedge pclk);
    fill <= 1'h0;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_obs(input int i, input logic v, input int lim);
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) tmo();
  endtask

  task automatic pwr;
    sensors_t p;
    p = base;
    p.power_off = 1'h1;
    drive(p);
    clk(4);
    drive(base);
    clk(6);
    check(alarm, 10'h0);
  endtask

  function automatic sensors_t mk(input int k);
    sensors_t m;
    m = base;
    case (k)
      0: m.weight_link_err = 1'h1;
      1: m.weight_sensor_bad = 1'h1;
      2: m.zero_cross_offset_fail = 1'h1;
      3: m.zero_cross_missing = 1'h1;
      4: m.brine_drive = 1'h1;
      5: m.brine_active = 1'h1;
      10: begin
        m.brine_drive = 1'h1;
        m.brine_current = 1'h1;
        m.brine_active = 1'h1;
      end
      default: begin
        m.diag_mode = 1'h1;
        m.heater_test_step = 1'h1;
        m.water_load_g = LOADS[k-6];
      end
    endcase
    return m;
  endfunction

  initial begin
    base = '0;
    base.sat_link_ok = 1'h1;
    base.aux_load_triac_sense_hi = 1'h1;
    cmd = base;
    {psel, penable, pwrite, fill, stuck, presetn} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    clk(8);
    presetn <= 1'h1;
    clk(1);
    check({irq, alarm}, 11'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, 12'(4 * i), 32'h0);
      check(rd, {31'h0, i == 3});
      check(er, i == 4);
    end
    apb(1'h1, MASK_OFF, 32'hffffffff);
    apb(1'h0, MASK_OFF, 32'h0);
    check(rd, 32'h3ff);
    apb(1'h1, MASK_OFF, 32'h0);
    for (int i = 0; i < NR; i++) begin
      drive(mk(i));
      clk(12);
      check(obs[IA[i]], EX[i]);
      check(obs[IB[i]], EX[i]);
      check(irq, 1'h0);
      drive(base);
      s = base;
      s.start_pause = 1'h1;
      drive(s);
      clk(4);
      drive(base);
      clk(6);
      check(alarm[IA[i]], EX[i] && IA[i] > A_WFAULT);
      pwr();
    end
    apb(1'h1, STATUS_OFF, 32'h3ff);
    apb(1'h1, CTRL_OFF, 32'h0);
    drive(mk(0));
    clk(12);
    check(alarm[A_WLINK], 1'h0);
    apb(1'h1, CTRL_OFF, 32'h1);
    apb(1'h1, MASK_OFF, 32'h200);
    drive(mk(4));
    clk(12);
    check(irq, 1'h1);
    apb(1'h0, STATUS_OFF, 32'h0);
    check(rd, 32'h202);
    apb(1'h1, STATUS_OFF, 32'h200);
    clk(2);
    check(irq, 1'h0);
    apb(1'h0, ALARM_OFF, 32'h0);
    check(rd, 32'h202);
    apb(1'h1, MASK_OFF, 32'h0);
    pwr();
    // diagnostic flow, broken once, then held
    s = base;
    s.diag_mode = 1'h1;
    s.flow_running = 1'h1;
    fillup(1'h0);
    drive(s);
    clk(30 * TK);
    s.flow_running = 1'h0;
    drive(s);
    clk(8);
    check(alarm[A_VALVE], 1'h0);
    s.flow_running = 1'h1;
    drive(s);
    wait_obs(A_VALVE, 1'h1, 400);
    check(n >= (VALVE_DIAG_T - 1) * TK, 1'h1);
    clk(3);
    check({act.door_lock, act.drain_pump}, 2'h3);
    wait_obs(DP, 1'h0, 200);
    check(act.door_lock, 1'h1);
    pwr();
    // normal flow with a stuck level switch
    s = base;
    s.flow_running = 1'h1;
    fillup(1'h1);
    drive(s);
    wait_obs(A_VALVE, 1'h1, 3000);
    check(n >= (VALVE_NORM_T - 1) * TK, 1'h1);
    drive(base);
    wait_obs(DP, 1'h1, 20);
    wait_obs(DP, 1'h0, 13000);
    check(n >= (DRAIN_MAX_T - 1) * TK, 1'h1);
    wait_obs(DP, 1'h1, 13000);
    check(n >= (PUMP_OFF_T - 1) * TK, 1'h1);
    fillup(1'h0);
    pwr();
    // shorted triac, two trials
    s = base;
    s.aux_load_triac_sense_hi = 1'h0;
    drive(s);
    wait_obs(A_LTRIAC, 1'h1, 1000);
    check(n >= (2 * TRIAC_T + TRIAC_PAUSE_T - 1) * TK, 1'h1);
    wait_obs(DR, 1'h1, 400);
    pwr();
    // open load in set-up mode, one trial
    s = base;
    s.setup_mode = 1'h1;
    s.aux_load_triac_drive = 1'h1;
    drive(s);
    wait_obs(A_LTRIAC, 1'h1, (TRIAC_T + 2) * TK + 8);
    pwr();
    // sensing at and above the positive limit
    s = base;
    s.half_wave_pos = 1'h1;
    s.triac_sense_adc = 8'hfa;
    fillup(1'h0);
    drive(s);
    clk(15 * TK);
    check(alarm[A_TSENSE], 1'h0);
    s.triac_sense_adc = 8'hfb;
    drive(s);
    wait_obs(A_TSENSE, 1'h1, 100);
    check(n >= (TSENSE_T - 1) * TK, 1'h1);
    wait_obs(DR, 1'h1, 400);
    check(act.machine_stop, 1'h1);
    s.power_fail = 1'h1;
    drive(s);
    wait_obs(DP, 1'h1, 40);
    pwr();
    s = base;
    s.sat_link_ok = 1'h0;
    drive(s);
    wait_obs(A_SATLINK, 1'h1, 1100);
    check(n >= (SAT_LINK_T - 1) * TK, 1'h1);
    pwr();
    s = base;
    s.sat_board_fault = 1'h1;
    drive(s);
    wait_obs(SP, 1'h0, 100);
    wait_obs(A_SATBOARD, 1'h1, 2500);
    check(n >= (4 * SAT_PAUSE_T - 4) * TK, 1'h1);
    clk(2);
    check(obs[MS], 1'h1);
    pwr();
    s = base;
    s.regen_active = 1'h1;
    drive(s);
    clk(20);
    drive(base);
    clk(10);
    check(alarm[A_SOFTENER], 1'h1);
    pwr();
    report_and_stop();
  end
endmodule
`default_nettype wire
